// ==== core/atbtl_pkg.sv ====
// constants shared by the a-then-b trigger logic
package atbtl_pkg;

  // ****************************************
  // structure
  // ****************************************
  localparam int ATBTL_CHANNELS = 4;
  localparam int ATBTL_PRODUCTS = 4;
  localparam int ATBTL_SHIFT_CELLS = 48;
  localparam int ATBTL_PROD_BITS = 12;

  // ****************************************
  // product indices
  // ****************************************
  localparam int ATBTL_A_FIRST = 0;
  localparam int ATBTL_A_SECOND = 1;
  localparam int ATBTL_B_FIRST = 2;
  localparam int ATBTL_B_SECOND = 3;

  // ****************************************
  // per-product field layout inside the control word
  // ****************************************
  localparam int ATBTL_FLD_USE_LSB = 0;
  localparam int ATBTL_FLD_INV_LSB = 4;
  localparam int ATBTL_FLD_ESEL_LSB = 8;
  localparam int ATBTL_FLD_EON_POS = 10;
  localparam int ATBTL_FLD_ENEG_POS = 11;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [47:0] ATBTL_SHIFT_RESET = 48'h0000_0000_0000;
  localparam logic [47:0] ATBTL_CFG_RESET = 48'h0000_0000_0000;
  localparam logic ATBTL_LATCH_RESET = 1'h0;
  localparam logic ATBTL_EXTSYNC_RESET = 1'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int ATBTL_CLK_PERIOD_NS = 20;
  localparam int ATBTL_STROBE_NS = 5;
  localparam int ATBTL_STROBE_CYCLES =
    (ATBTL_STROBE_NS / ATBTL_CLK_PERIOD_NS < 1) ? 1 : ATBTL_STROBE_NS / ATBTL_CLK_PERIOD_NS;
  localparam logic [3:0] ATBTL_STROBE_LOAD = 4'(ATBTL_STROBE_CYCLES);

endpackage : atbtl_pkg

// ==== core/atbtl_trigger.sv ====
// a-then-b trigger qualification: products, strobes, sequencing latch, readback
// Function
// [RULE1] edge-sensitive channel in a product drives that product's edge enable low
// [RULE2] external edge enable held low while external sync is selected
// [RULE3] second press of sync control deselects it, edge enable returns high
// [RULE4] edge product emits short strobe right after its mux output transition
// [RULE5] product configuration and thresholds loaded serially by controller
// [RULE6] 48-cell control shift register, serial output on readback five
// [RULE7] in conversion, comparator routed via b second mux to readback two
// [RULE8] controller repeats conversion via a first product only after error
// [RULE9] function a observable on readback three, function b on four
// [RULE10] latch sets when function a asserts, absent reset
// [RULE11] set latch stays set after function a drops until reset
// [RULE12] sequencing reset line high clears latch, readback zero low
// [RULE13] trigger enable low clears the sequencing latch
// [RULE14] function b assertion clears set latch
// [RULE15] edge product asserts function a only when its strobe fires
// [RULE16] function b products likewise gated by their strobes
// [RULE17] each product takes any channel or complement, either edge polarity
// [RULE18] external clock path active only while sync selected
// [RULE19] reset wins over simultaneous set
// [RULE20] latch state shown continuously on readback zero
`timescale 1ns/1ps
module atbtl_trigger
  import atbtl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ATBTL_CHANNELS-1:0] chanIn,
  input wire logic extClkIn,
  input wire logic extClkSlope,
  input wire logic extSyncPress,
  input wire logic shiftStrobe,
  input wire logic shiftData,
  input wire logic loadStrobe,
  input wire logic convMode,
  input wire logic [1:0] convChannel,
  input wire logic trigEnableLine,
  input wire logic seqResetLine,
  output logic [ATBTL_PRODUCTS-1:0] edgeEnNProduct,
  output logic extSyncEdgeEnN,
  output logic extSyncSelected,
  output logic strobeAFirst,
  output logic strobeASecond,
  output logic strobeBFirst,
  output logic strobeBSecond,
  output logic funcAOut,
  output logic funcBOut,
  output logic readbackZero,
  output logic readbackTwo,
  output logic readbackThree,
  output logic readbackFour,
  output logic readbackFive
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [ATBTL_PROD_BITS-1:0] prodField(input logic [47:0] w, input int p);
    prodField = w[p*ATBTL_PROD_BITS +: ATBTL_PROD_BITS];
  endfunction : prodField

  function automatic logic prodLevel(input logic [ATBTL_PROD_BITS-1:0] f,
                                     input logic [ATBTL_CHANNELS-1:0] ch);
    logic [3:0] use4;
    logic [3:0] inv4;
    use4 = f[ATBTL_FLD_USE_LSB +: 4];
    inv4 = f[ATBTL_FLD_INV_LSB +: 4];
    prodLevel = (&(~use4 | (ch ^ inv4))) & ((|use4) | f[ATBTL_FLD_EON_POS]);
  endfunction : prodLevel

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [ATBTL_CHANNELS-1:0] chanMeta_reg, chanMeta_next;
  logic [ATBTL_CHANNELS-1:0] chanSync_reg, chanSync_next;
  logic extMeta_reg, extMeta_next;
  logic extSync_reg, extSync_next;
  logic extPrev_reg, extPrev_next;
  logic extEdge;

  always_comb begin
    chanMeta_next = chanIn;
    chanSync_next = chanMeta_reg;
    extMeta_next = extClkIn;
    extSync_next = extMeta_reg;
    extPrev_next = extSync_reg ^ extClkSlope;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chanMeta_reg <= 4'h0;
      chanSync_reg <= 4'h0;
      extMeta_reg <= 1'h0;
      extSync_reg <= 1'h0;
      extPrev_reg <= 1'h0;
    end else begin
      chanMeta_reg <= chanMeta_next;
      chanSync_reg <= chanSync_next;
      extMeta_reg <= extMeta_next;
      extSync_reg <= extSync_next;
      extPrev_reg <= extPrev_next;
    end
  end

  assign extEdge = (extSync_reg ^ extClkSlope) & ~extPrev_reg;

  // ****************************************
  // control shift register and shadow
  // ****************************************
  logic [ATBTL_SHIFT_CELLS-1:0] shift_reg, shift_next;
  logic [ATBTL_SHIFT_CELLS-1:0] cfg_reg, cfg_next;
  logic extSel_reg, extSel_next;

  always_comb begin
    shift_next = shift_reg;
    cfg_next = cfg_reg;
    extSel_next = extSel_reg;
    // [RULE5] serial load
    if (shiftStrobe) begin
      shift_next = {shift_reg[ATBTL_SHIFT_CELLS-2:0], shiftData};
    end
    if (loadStrobe) begin
      cfg_next = shift_reg;
    end
    // [RULE3] press toggles sync
    if (extSyncPress) begin
      extSel_next = ~extSel_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_reg <= ATBTL_SHIFT_RESET;
      cfg_reg <= ATBTL_CFG_RESET;
      extSel_reg <= ATBTL_EXTSYNC_RESET;
    end else begin
      shift_reg <= shift_next;
      cfg_reg <= cfg_next;
      extSel_reg <= extSel_next;
    end
  end

  // ****************************************
  // edge multiplexers, strobes, products
  // ****************************************
  logic [ATBTL_PRODUCTS-1:0] muxOut;
  logic [ATBTL_PRODUCTS-1:0] muxPrev_reg, muxPrev_next;
  logic [ATBTL_PRODUCTS-1:0] strobe_reg, strobe_next;
  logic [ATBTL_PRODUCTS-1:0] edgeEn_reg, edgeEn_next;
  logic [ATBTL_PRODUCTS-1:0] prodOut;
  logic [3:0] strobeCnt_reg [ATBTL_PRODUCTS];
  logic [3:0] strobeCnt_next [ATBTL_PRODUCTS];

  genvar gp;
  generate
    for (gp = 0; gp < ATBTL_PRODUCTS; gp++) begin : gProd
      logic [ATBTL_PROD_BITS-1:0] fld;
      logic [1:0] sel;
      logic neg;
      assign fld = prodField(cfg_reg, gp);
      // [RULE7] conversion steers b second mux
      assign sel = (gp == ATBTL_B_SECOND && convMode) ? convChannel
                                                      : fld[ATBTL_FLD_ESEL_LSB +: 2];
      assign neg = (gp == ATBTL_B_SECOND && convMode) ? 1'h0 : fld[ATBTL_FLD_ENEG_POS];
      // [RULE17] channel with chosen polarity
      assign muxOut[gp] = chanSync_reg[sel] ^ neg;

      always_comb begin
        muxPrev_next[gp] = muxOut[gp];
        // [RULE1] edge enable low
        edgeEn_next[gp] = ~fld[ATBTL_FLD_EON_POS];
        // [RULE4] strobe after transition
        if (fld[ATBTL_FLD_EON_POS] && muxOut[gp] && !muxPrev_reg[gp]) begin
          strobeCnt_next[gp] = ATBTL_STROBE_LOAD;
        end else if (strobeCnt_reg[gp] != 4'h0) begin
          strobeCnt_next[gp] = strobeCnt_reg[gp] - 4'h1;
        end else begin
          strobeCnt_next[gp] = 4'h0;
        end
        strobe_next[gp] = (strobeCnt_next[gp] != 4'h0);
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          strobeCnt_reg[gp] <= 4'h0;
        end else begin
          strobeCnt_reg[gp] <= strobeCnt_next[gp];
        end
      end

      // [RULE15] strobe gates edge product
      // [RULE16] same gating for b
      assign prodOut[gp] = prodLevel(fld, chanSync_reg) &
                           (~fld[ATBTL_FLD_EON_POS] | strobe_reg[gp]);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      muxPrev_reg <= 4'h0;
      strobe_reg <= 4'h0;
      edgeEn_reg <= 4'hF;
    end else begin
      muxPrev_reg <= muxPrev_next;
      strobe_reg <= strobe_next;
      edgeEn_reg <= edgeEn_next;
    end
  end

  // ****************************************
  // functions and sequencing latch
  // ****************************************
  logic funcA_reg, funcA_next;
  logic funcB_reg, funcB_next;
  logic latch_reg, latch_next;
  logic rdTwo_reg, rdTwo_next;
  logic extGate;

  // [RULE18] ext clock only when selected
  assign extGate = ~extSel_reg | extEdge;

  always_comb begin
    funcA_next = (prodOut[ATBTL_A_FIRST] | prodOut[ATBTL_A_SECOND]) & extGate;
    funcB_next = (prodOut[ATBTL_B_FIRST] | prodOut[ATBTL_B_SECOND]) & extGate;
    rdTwo_next = muxOut[ATBTL_B_SECOND];
    // [RULE19] reset has priority
    if (seqResetLine || !trigEnableLine || funcB_reg) begin
      // [RULE12] reset line clears
      // [RULE13] enable low clears
      // [RULE14] function b clears
      latch_next = 1'h0;
    end else if (funcA_reg) begin
      // [RULE10] set by function a
      latch_next = 1'h1;
    end else begin
      // [RULE11] hold until reset
      latch_next = latch_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      funcA_reg <= 1'h0;
      funcB_reg <= 1'h0;
      latch_reg <= ATBTL_LATCH_RESET;
      rdTwo_reg <= 1'h0;
    end else begin
      funcA_reg <= funcA_next;
      funcB_reg <= funcB_next;
      latch_reg <= latch_next;
      rdTwo_reg <= rdTwo_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign edgeEnNProduct = edgeEn_reg;
  // [RULE2] low while sync selected
  assign extSyncEdgeEnN = ~extSel_reg;
  assign extSyncSelected = extSel_reg;
  assign strobeAFirst = strobe_reg[ATBTL_A_FIRST];
  assign strobeASecond = strobe_reg[ATBTL_A_SECOND];
  assign strobeBFirst = strobe_reg[ATBTL_B_FIRST];
  assign strobeBSecond = strobe_reg[ATBTL_B_SECOND];
  assign funcAOut = funcA_reg;
  assign funcBOut = funcB_reg;
  // [RULE20] latch on readback zero
  assign readbackZero = latch_reg;
  // [RULE7] comparator feedback
  assign readbackTwo = rdTwo_reg;
  // [RULE9] function readbacks
  // [RULE8] second conversion path via a first product
  assign readbackThree = funcA_reg;
  assign readbackFour = funcB_reg;
  // [RULE6] serial output
  assign readbackFive = shift_reg[ATBTL_SHIFT_CELLS-1];

endmodule : atbtl_trigger

// ==== verification/atbtl_ctrl_model.sv ====
// controller model: serial load of the trigger control word
`timescale 1ns/1ps
module atbtl_ctrl_model
  import atbtl_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic doLoad,
  input wire logic [ATBTL_SHIFT_CELLS-1:0] word,
  output logic shiftStrobe,
  output logic shiftData,
  output logic loadStrobe,
  output logic busy
);
  initial begin
    shiftStrobe = 1'h0;
    shiftData = 1'h0;
    loadStrobe = 1'h0;
    busy = 1'h0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'h1;
        for (int i = ATBTL_SHIFT_CELLS - 1; i >= 0; i--) begin
          shiftStrobe <= 1'h1;
          shiftData <= word[i];
          @(posedge clk);
        end
        shiftStrobe <= 1'h0;
        shiftData <= ~word[0];
        loadStrobe <= doLoad;
        @(posedge clk);
        loadStrobe <= 1'h0;
        busy <= 1'h0;
      end
    end
  end
endmodule : atbtl_ctrl_model

// ==== verification/atbtl_trigger_chk.sv ====
// port assertions for the a-then-b trigger logic
`timescale 1ns/1ps
module atbtl_trigger_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic extSyncPress,
  input wire logic shiftStrobe,
  input wire logic seqResetLine,
  input wire logic trigEnableLine,
  input wire logic extSyncEdgeEnN,
  input wire logic extSyncSelected,
  input wire logic strobeAFirst,
  input wire logic funcAOut,
  input wire logic funcBOut,
  input wire logic readbackZero,
  input wire logic readbackThree,
  input wire logic readbackFour,
  input wire logic readbackFive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_clear; seqResetLine || !trigEnableLine || funcBOut; endsequence
  sequence s_arm; !seqResetLine && trigEnableLine && !funcBOut; endsequence
  property p_toggle; extSyncPress |=> extSyncSelected != $past(extSyncSelected); endproperty
  a_toggle: assert property (p_toggle)
    else $error("sync selection did not toggle");
  property p_ext_en; extSyncEdgeEnN == !extSyncSelected; endproperty
  a_ext_en: assert property (p_ext_en)
    else $error("ext edge enable wrong");
  property p_fa; readbackThree == funcAOut; endproperty
  a_fa: assert property (p_fa)
    else $error("function a readback wrong");
  property p_fb; readbackFour == funcBOut; endproperty
  a_fb: assert property (p_fb)
    else $error("function b readback wrong");
  property p_clear; s_clear |=> !readbackZero; endproperty
  a_clear: assert property (p_clear)
    else $error("latch not cleared");
  property p_set; s_arm ##0 funcAOut |=> readbackZero; endproperty
  a_set: assert property (p_set)
    else $error("latch not set");
  property p_hold; s_arm ##0 readbackZero |=> readbackZero; endproperty
  a_hold: assert property (p_hold)
    else $error("latch lost");
  property p_strobe; strobeAFirst |=> !strobeAFirst; endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe too long");
  property p_serial; !shiftStrobe |=> $stable(readbackFive); endproperty
  a_serial: assert property (p_serial)
    else $error("serial out moved without shift");
endmodule : atbtl_trigger_chk
bind atbtl_trigger atbtl_trigger_chk u_chk (.clk(clk), .rst(rst), .extSyncPress(extSyncPress),
  .shiftStrobe(shiftStrobe), .seqResetLine(seqResetLine), .trigEnableLine(trigEnableLine),
  .extSyncEdgeEnN(extSyncEdgeEnN), .extSyncSelected(extSyncSelected),
  .strobeAFirst(strobeAFirst), .funcAOut(funcAOut), .funcBOut(funcBOut),
  .readbackZero(readbackZero), .readbackThree(readbackThree), .readbackFour(readbackFour),
  .readbackFive(readbackFive));

// ==== verification/a_then_b_trigger_logic_tb.sv ====
// self-checking testbench for the a-then-b trigger logic
`timescale 1ns/1ps
module a_then_b_trigger_logic_tb
  import atbtl_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] chanIn = 4'h0;
  logic [1:0] convChannel = 2'h0;
  logic extClkIn = 1'h0;
  logic extClkSlope = 1'h0;
  logic extSyncPress = 1'h0, convMode = 1'h0, trigEnableLine = 1'h1, seqResetLine = 1'h0;
  logic go = 1'h0, doLoad = 1'h0, shiftStrobe, shiftData, loadStrobe, busy;
  logic [47:0] word = 48'h0;
  logic [3:0] edgeEnNProduct;
  logic extSyncEdgeEnN, extSyncSelected, strobeAFirst, strobeASecond, strobeBFirst;
  logic strobeBSecond, funcAOut, funcBOut, readbackZero, readbackTwo, readbackThree;
  logic readbackFour, readbackFive;
  logic [15:0] lfsrState = 16'hE12A;
  int n_mismatch = 0;
  int check_count = 0;
  always #10 clk = ~clk;
  atbtl_ctrl_model ctrl (.clk(clk), .go(go), .doLoad(doLoad), .word(word),
    .shiftStrobe(shiftStrobe), .shiftData(shiftData), .loadStrobe(loadStrobe), .busy(busy));
  atbtl_trigger dut (.clk(clk), .rst(rst), .chanIn(chanIn), .extClkIn(extClkIn),
    .extClkSlope(extClkSlope), .extSyncPress(extSyncPress), .shiftStrobe(shiftStrobe),
    .shiftData(shiftData), .loadStrobe(loadStrobe), .convMode(convMode),
    .convChannel(convChannel), .trigEnableLine(trigEnableLine), .seqResetLine(seqResetLine),
    .edgeEnNProduct(edgeEnNProduct), .extSyncEdgeEnN(extSyncEdgeEnN),
    .extSyncSelected(extSyncSelected), .strobeAFirst(strobeAFirst),
    .strobeASecond(strobeASecond), .strobeBFirst(strobeBFirst), .strobeBSecond(strobeBSecond),
    .funcAOut(funcAOut), .funcBOut(funcBOut), .readbackZero(readbackZero),
    .readbackTwo(readbackTwo), .readbackThree(readbackThree), .readbackFour(readbackFour),
    .readbackFive(readbackFive));
  function automatic logic [15:0] rnd();
    lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
    return lfsrState;
  endfunction : rnd
  function automatic logic [47:0] prod_cfg(input int p, input logic [11:0] f);
    return 48'(f) << (ATBTL_PROD_BITS * p);
  endfunction : prod_cfg
  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk_bit
  task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp, input string what);
    chk_bit(1'(got === exp), 1'h1, what);
  endtask : chk_vec
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  task automatic wait_bit(ref logic sig, input logic val, input int lim);
    int k;
    k = 0;
    #1;
    while (sig !== val) begin
      if (k++ == lim) begin
        chk_bit(1'h0, 1'h1, "wait limit");
        wrap_up();
      end
      @(posedge clk);
      #1;
    end
    chk_bit(sig, val, "awaited level");
    @(posedge clk);
  endtask : wait_bit
  task automatic load(input logic [47:0] w, input logic ld);
    @(posedge clk);
    word <= w;
    doLoad <= ld;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    wait_bit(busy, 1'h0, 60);
    repeat (2) @(posedge clk);
  endtask : load
  initial begin
    logic [15:0] r;
    logic [3:0] u;
    logic [47:0] w;
    logic seen, hit;
    logic [3:0] stb;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1;
    chk_bit(readbackZero, 1'h0, "latch after reset");
    chk_vec(edgeEnNProduct, 4'hF, "edge enables after reset");
    w = {rnd(), rnd(), rnd()};
    load(w, 1'h0);
    #1;
    chk_bit(readbackFive, w[47], "serial out");
    load(~w, 1'h0);
    #1;
    chk_bit(readbackFive, ~w[47], "serial out");
    $display("test shift done");
    load(prod_cfg(0, 12'h001) | prod_cfg(2, 12'h002), 1'h1);
    chanIn <= 4'h1;
    wait_bit(readbackThree, 1'h1, 8);
    wait_bit(readbackZero, 1'h1, 4);
    chanIn <= 4'h0;
    repeat (6) @(posedge clk);
    #1;
    chk_bit(readbackZero, 1'h1, "latch holds");
    @(posedge clk);
    seqResetLine <= 1'h1;
    chanIn <= 4'h1;
    repeat (6) @(posedge clk);
    #1;
    chk_bit(readbackZero, 1'h0, "reset beats set");
    @(posedge clk);
    seqResetLine <= 1'h0;
    wait_bit(readbackZero, 1'h1, 8);
    trigEnableLine <= 1'h0;
    wait_bit(readbackZero, 1'h0, 4);
    trigEnableLine <= 1'h1;
    wait_bit(readbackZero, 1'h1, 8);
    chanIn <= 4'h2;
    wait_bit(readbackFour, 1'h1, 8);
    wait_bit(readbackZero, 1'h0, 4);
    $display("test latch done");
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      r = rnd();
      u = 4'h1 << ((r[1:0] + 2'h1));
      w = prod_cfg(p, {r[2], 1'h1, r[1:0], 4'h0, (p < 2) ? u : 4'h0});
      w = w | ((p < 2) ? 48'h0 : prod_cfg(0, {8'h00, u}));
      chanIn <= u | (r[2] ? 4'h1 << r[1:0] : 4'h0);
      seqResetLine <= 1'h1;
      load(w, 1'h1);
      seqResetLine <= 1'h0;
      repeat (8) @(posedge clk);
      #1;
      chk_vec(edgeEnNProduct, ~(4'h1 << p), "edge enable");
      chk_bit(readbackZero, 1'(p >= 2), "static level only");
      @(posedge clk);
      chanIn[r[1:0]] <= ~r[2];
      seen = 1'h0;
      hit = 1'h0;
      repeat (10) begin
        @(posedge clk);
        #1;
        stb = {strobeBSecond, strobeBFirst, strobeASecond, strobeAFirst};
        seen = seen | (stb[p] === 1'h1);
        hit = hit | (readbackZero === 1'(p < 2));
      end
      chk_bit(seen, 1'h1, "edge strobe");
      chk_bit(hit, 1'h1, "edge moves latch");
    end
    $display("test edges done");
    @(posedge clk);
    convMode <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      @(posedge clk);
      chanIn <= r[3:0];
      convChannel <= 2'(k);
      repeat (5) @(posedge clk);
      #1;
      chk_bit(readbackTwo, r[k], "conversion path");
      if (readbackTwo !== r[k]) begin
        load(prod_cfg(0, {8'h00, 4'h1 << k}), 1'h1);
        #1;
        chk_bit(readbackThree, r[k], "second conversion path");
      end
    end
    $display("test conversion done");
    @(posedge clk);
    convMode <= 1'h0;
    chanIn <= 4'hF;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      extSyncPress <= 1'h1;
      @(posedge clk);
      extSyncPress <= 1'h0;
      #1;
      chk_bit(extSyncEdgeEnN, 1'(k), "ext edge enable");
      repeat (2) @(posedge clk);
      #1;
      chk_bit(readbackThree, 1'(k), "ext gate");
      @(posedge clk);
      extClkIn <= ~extClkIn;
      hit = 1'h0;
      repeat (5) begin
        @(posedge clk);
        #1;
        hit = hit | (readbackThree === 1'h1);
      end
      chk_bit(hit, 1'h1, "ext edge passes");
    end
    $display("test sync done");
    wrap_up();
  end
endmodule : a_then_b_trigger_logic_tb
